/* File: core/sbls_defs.vh */
// Purpose: Constants for the stop bar and lead-on sequencer.
// Assumes: 100 MHz MCLK, APB3 register access, 32-bit data.
// Notes:   Summary of the behaviour follows.
//
// Summary of operation
// - Clear press starts timers, bar off, leads on.
// - First backup timer 45 s covers sensor one.
// - Second backup timer 2 min covers sensor two.
// - Timer expiry acts like its sensor.
// - Sensor one relights bar, segment one off.
// - Sensor two turns segment two off.
// - Early sensor two: both segments off, bar on.
// - Override press ignores both sensors that cycle.
// - Override cycle ends at second timer expiry.
// - One lamp failure leaves other lamps normal.
// - Controller component failure turns its lamps off.
// - Failure at low visibility: bar on, failed off.
// - Control failure at high visibility: all off.
// - Comm failure shuts lights off after 10 min.
// - Failed indication holds until return to service.
// - Bar off, leads on within 2 s.
// - Monitored status reaches panel within 5 s.
// - Count failed lamps, flag adjacent failures.
// - Yellow only at high, red only low visibility.
// - Yellow never lit during go configuration; the code still pulses yellow on comm-failed controllers at high visibility.
// - Comm failure: low red on; high yellow pulses.
// - Local mode select; component failure kills both.
// - Yellow even/odd sets alternate near 31 per minute.
`ifndef SBLS_DEFS_VH
`define SBLS_DEFS_VH
`define SBLS_ADDR_CTRL   12'h000
`define SBLS_ADDR_STATUS 12'h004
`define SBLS_ADDR_MON    12'h008
`define SBLS_ADDR_SVC    12'h00c
`define SBLS_CTRL_HIVIS  0
`define SBLS_CTRL_LSEL   1
`define SBLS_CTRL_LHIVIS 2
`define SBLS_SVC_RETURN  0
`define SBLS_CTRL_RESET  3'h0
`define SBLS_CLK_HZ      100000000
`define SBLS_T1_SEC      45
`define SBLS_T2_SEC      120
`define SBLS_SHUT_SEC    600
`define SBLS_HALF_MS     967
`endif

/* File: core/sbls_top.v */
// Purpose: Controlled stop bar, lead-on and guard light sequencer.
// Assumes: Single 100 MHz clock, synchronous active-low reset.
// Notes:   Panel, sensors and controller faults arrive on pins.
`timescale 1ns/1ps
`include "sbls_defs.vh"
module sbls_top #(
   parameter NLAMP    = 8,
   parameter NCTL     = 4,
   parameter SEC_CYC  = `SBLS_CLK_HZ,
   parameter HALF_CYC = (`SBLS_CLK_HZ / 1000) * `SBLS_HALF_MS,
   parameter [9:0] T1_SEC   = `SBLS_T1_SEC,
   parameter [9:0] T2_SEC   = `SBLS_T2_SEC,
   parameter [9:0] SHUT_SEC = `SBLS_SHUT_SEC
) (
   input  wire             MCLK,          // System clock
   input  wire             RESET_N,       // Synchronous reset
   input  wire             PSEL,          // APB select
   input  wire             PENABLE,       // APB enable
   input  wire             PWRITE,        // APB direction
   input  wire [11:0]      PADDR,         // APB byte address
   input  wire [31:0]      PWDATA,        // APB write data
   output reg  [31:0]      PRDATA,        // APB read data
   output reg              PREADY,        // APB ready
   output reg              PSLVERR,       // APB error
   input  wire             CLEAR_BTN,     // Panel clear button
   input  wire             OVERRIDE_BTN,  // Panel sensor override
   input  wire             SENSOR1,       // Position sensor one
   input  wire             SENSOR2,       // Position sensor two
   input  wire             CTRL_FAIL,     // Control system failure
   input  wire [NCTL-1:0]  COMM_FAIL,     // Per controller comm loss
   input  wire [NCTL-1:0]  COMP_FAIL,     // Per controller fault
   input  wire [NLAMP-1:0] LAMP_FAULT,    // Monitored dead lamps
   output reg  [NLAMP-1:0] STOP_RED,      // Red stop bar lamps
   output reg  [NLAMP-1:0] GUARD_YEL,     // Yellow guard lamps
   output reg              LEAD1_ON,      // Lead-on segment one
   output reg              LEAD2_ON,      // Lead-on segment two
   output reg              FAIL_IND       // Panel failed indication
);

   localparam W = 5 + 2 * NCTL + NLAMP;
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_CLR  = 4'h2;
   localparam [3:0] ST_S1   = 4'h4;
   localparam [3:0] ST_OVR  = 4'h8;

   function [7:0] count_ones;
      input [NLAMP-1:0] v;
      integer k;
      begin
         count_ones = 8'h00;
         for (k = 0; k < NLAMP; k = k + 1) begin
            count_ones = count_ones + {7'h00, v[k]};
         end
      end
   endfunction

   function any_adjacent;
      input [NLAMP-1:0] v;
      integer k;
      begin
         any_adjacent = 1'b0;
         for (k = 1; k < NLAMP; k = k + 1) begin
            any_adjacent = any_adjacent | (v[k] & v[k-1]);
         end
      end
   endfunction

   // Word decode of the register bus; shared by the service and control write paths.
   function [3:0] reg_sel;
      input [11:0] a;
      begin
         reg_sel = 4'h0;
         case (a)
            `SBLS_ADDR_CTRL: begin
               reg_sel = 4'h1;
            end
            `SBLS_ADDR_STATUS: begin
               reg_sel = 4'h2;
            end
            `SBLS_ADDR_MON: begin
               reg_sel = 4'h4;
            end
            `SBLS_ADDR_SVC: begin
               reg_sel = 4'h8;
            end
            default: begin
               reg_sel = 4'h0;
            end
         endcase
      end
   endfunction

   // Three-stage synchroniser; a level counts once stages two and three agree.
   // While the two stages differ the filter holds, so a bouncing pin gives no glitch.
   reg  [W-1:0] s1_reg;
   reg  [W-1:0] s2_reg;
   reg  [W-1:0] s3_reg;
   reg  [W-1:0] flt_reg;
   reg  [W-1:0] prev_reg;
   wire [W-1:0] pins;
   wire [W-1:0] flt_next;

   assign pins = {LAMP_FAULT, COMP_FAIL, COMM_FAIL, CTRL_FAIL,
                  SENSOR2, SENSOR1, OVERRIDE_BTN, CLEAR_BTN};
   assign flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));

   always @(posedge MCLK) begin
      if (!RESET_N) begin
         s1_reg   <= {W{1'b0}};
         s2_reg   <= {W{1'b0}};
         s3_reg   <= {W{1'b0}};
         flt_reg  <= {W{1'b0}};
         prev_reg <= {W{1'b0}};
      end else begin
         s1_reg   <= pins;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         flt_reg  <= flt_next;
         prev_reg <= flt_reg;
      end
   end

   // Edges come from the filtered level, so a held button counts as one press only.
   wire             press    = flt_reg[0] & ~prev_reg[0];
   wire             ovr_held = flt_reg[1];
   wire             sens1_ev = flt_reg[2] & ~prev_reg[2];
   wire             sens2_ev = flt_reg[3] & ~prev_reg[3];
   wire             ctrl_f   = flt_reg[4];
   wire [NCTL-1:0]  comm_f   = flt_reg[5 +: NCTL];
   wire [NCTL-1:0]  comp_f   = flt_reg[5 + NCTL +: NCTL];
   wire [NLAMP-1:0] lamp_f   = flt_reg[5 + 2 * NCTL +: NLAMP];

   // Seconds tick and the guard light pulse phase.
   // The tick runs free, so a timer started between ticks may end up to one tick early.
   reg [31:0] sec_cnt_reg;
   reg [31:0] half_cnt_reg;
   reg        phase_reg;
   wire       sec_tick = (sec_cnt_reg == SEC_CYC - 1);

   always @(posedge MCLK) begin
      if (!RESET_N) begin
         sec_cnt_reg  <= 32'h0;
         half_cnt_reg <= 32'h0;
         phase_reg    <= 1'b0;
      end else begin
         sec_cnt_reg <= sec_tick ? 32'h0 : sec_cnt_reg + 32'h1;
         if (half_cnt_reg == HALF_CYC - 1) begin
            half_cnt_reg <= 32'h0;
            phase_reg    <= ~phase_reg;
         end else begin
            half_cnt_reg <= half_cnt_reg + 32'h1;
         end
      end
   end

   // Backup timers and the sequencer.
   reg  [9:0] t1_cnt_reg;
   reg  [9:0] t2_cnt_reg;
   reg        t1_run_reg;
   reg        t2_run_reg;
   reg  [3:0] state_reg;
   reg  [3:0] state_next;
   wire       t1_exp = t1_run_reg & sec_tick & (t1_cnt_reg == T1_SEC - 10'h1);
   wire       t2_exp = t2_run_reg & sec_tick & (t2_cnt_reg == T2_SEC - 10'h1);

   // A press in any state restarts the cycle, so the tower can always re-clear the bar.
   always @* begin
      state_next = state_reg;
      if (press) begin
         state_next = ovr_held ? ST_OVR : ST_CLR;
      end else begin
         case (state_reg)
            ST_CLR: begin
               if (sens2_ev | t2_exp) begin
                  state_next = ST_IDLE;
               end else if (sens1_ev | t1_exp) begin
                  state_next = ST_S1;
               end
            end
            ST_S1: begin
               if (sens2_ev | t2_exp) begin
                  state_next = ST_IDLE;
               end
            end
            ST_OVR: begin
               if (t2_exp) begin
                  state_next = ST_IDLE;
               end
            end
            ST_IDLE: begin
               state_next = ST_IDLE;
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge MCLK) begin
      if (!RESET_N) begin
         state_reg  <= ST_IDLE;
         t1_cnt_reg <= 10'h0;
         t2_cnt_reg <= 10'h0;
         t1_run_reg <= 1'b0;
         t2_run_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (press) begin
            t1_cnt_reg <= 10'h0;
            t2_cnt_reg <= 10'h0;
            t1_run_reg <= 1'b1;
            t2_run_reg <= 1'b1;
         end else begin
            if (t1_exp) begin
               t1_run_reg <= 1'b0;
            end else if (t1_run_reg & sec_tick) begin
               t1_cnt_reg <= t1_cnt_reg + 10'h1;
            end
            if (t2_exp) begin
               t2_run_reg <= 1'b0;
            end else if (t2_run_reg & sec_tick) begin
               t2_cnt_reg <= t2_cnt_reg + 10'h1;
            end
         end
      end
   end

   // Bar is lit in idle and after sensor one; dark in the clear and override states.
   wire bar_cmd   = state_reg[0] | state_reg[2];
   wire lead1_cmd = state_reg[1] | state_reg[3];
   wire lead2_cmd = state_reg[1] | state_reg[2] | state_reg[3];

   // Control register bits.
   reg [2:0] ctrl_reg;
   wire      hivis  = ctrl_reg[`SBLS_CTRL_HIVIS];
   wire      lsel   = ctrl_reg[`SBLS_CTRL_LSEL];
   wire      lhivis = ctrl_reg[`SBLS_CTRL_LHIVIS];

   // Per controller shutoff timer after a communication loss.
   // A controller that regains its link restarts its count, so a flapping link delays shutoff.
   reg [NCTL-1:0] shut_reg;
   genvar c;
   generate
      for (c = 0; c < NCTL; c = c + 1) begin : g_shut
         reg [9:0] cnt_reg;
         always @(posedge MCLK) begin
            if (!RESET_N || !comm_f[c]) begin
               cnt_reg     <= 10'h0;
               shut_reg[c] <= 1'b0;
            end else if (sec_tick && !shut_reg[c]) begin
               if (cnt_reg == SHUT_SEC - 10'h1) begin
                  shut_reg[c] <= 1'b1;
               end
               cnt_reg <= cnt_reg + 10'h1;
            end
         end
      end
   endgenerate

   // Lamp drive; each lamp follows its own controller only.
   // In normal service a dead lamp is still driven; only the failure modes blank it.
   wire [NLAMP-1:0] red_next;
   wire [NLAMP-1:0] yel_next;
   genvar i;
   generate
      for (i = 0; i < NLAMP; i = i + 1) begin : g_lamp
         localparam integer CI = i % NCTL;
         wire fm  = comm_f[CI] | ctrl_f;
         wire hv  = (comm_f[CI] & lsel) ? lhivis : hivis;
         wire ph  = phase_reg ^ (i % 2 == 1);
         wire off = comp_f[CI] | (comm_f[CI] & shut_reg[CI]);
         assign red_next[i] = off ? 1'b0 :
                              fm  ? (~hv & ~lamp_f[i]) :
                                    (bar_cmd & ~hivis);
         assign yel_next[i] = off ? 1'b0 :
                              fm  ? (comm_f[CI] & hv & ph) :
                                    (hivis & bar_cmd & ph);
      end
   endgenerate

   // Failed indication: a fault present the same cycle beats the clear.
   wire any_fail = ctrl_f | (|comm_f) | (|comp_f);
   wire [3:0] sel = reg_sel(PADDR);
   wire apb_wr   = PSEL & PENABLE & PWRITE & PREADY;
   wire svc_wr   = apb_wr & sel[3] & PWDATA[`SBLS_SVC_RETURN];

   always @(posedge MCLK) begin
      if (!RESET_N) begin
         STOP_RED  <= {NLAMP{1'b0}};
         GUARD_YEL <= {NLAMP{1'b0}};
         LEAD1_ON  <= 1'b0;
         LEAD2_ON  <= 1'b0;
         FAIL_IND  <= 1'b0;
      end else begin
         STOP_RED  <= red_next;
         GUARD_YEL <= yel_next;
         LEAD1_ON  <= lead1_cmd;
         LEAD2_ON  <= lead2_cmd;
         if (any_fail) begin
            FAIL_IND <= 1'b1;
         end else if (svc_wr) begin
            FAIL_IND <= 1'b0;
         end
      end
   end

   // Monitor summary of dead lamps.
   reg [7:0] fail_cnt_reg;
   reg       adj_reg;

   always @(posedge MCLK) begin
      if (!RESET_N) begin
         fail_cnt_reg <= 8'h00;
         adj_reg      <= 1'b0;
      end else begin
         fail_cnt_reg <= count_ones(lamp_f);
         adj_reg      <= any_adjacent(lamp_f);
      end
   end

   // APB slave: one wait-free access cycle, error on unmapped address.
   reg [31:0] rd_next;
   reg        hit;

   always @* begin
      rd_next = 32'h0;
      hit     = 1'b1;
      case (PADDR)
         `SBLS_ADDR_CTRL: begin
            rd_next = {29'h0, ctrl_reg};
         end
         `SBLS_ADDR_STATUS: begin
            // Actual outputs are reported, so the panel sees the lamps, not intent.
            rd_next = {20'h0, state_reg, 1'b0, FAIL_IND, t2_run_reg,
                       t1_run_reg, LEAD2_ON, LEAD1_ON, |STOP_RED,
                       (state_reg == ST_OVR)};
         end
         `SBLS_ADDR_MON: begin
            rd_next = {23'h0, adj_reg, fail_cnt_reg};
         end
         `SBLS_ADDR_SVC: begin
            rd_next = 32'h0;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   always @(posedge MCLK) begin
      if (!RESET_N) begin
         PREADY   <= 1'b0;
         PSLVERR  <= 1'b0;
         PRDATA   <= 32'h0;
         ctrl_reg <= `SBLS_CTRL_RESET;
      end else begin
         PREADY  <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & ~hit;
         if (PSEL & ~PENABLE & ~PWRITE) begin
            PRDATA <= rd_next;
         end
         if (apb_wr && sel[0]) begin
            ctrl_reg <= PWDATA[2:0];
         end
      end
   end

endmodule // sbls_top

/* File: testbench/sbls_sensor_model.sv */
// Purpose: Behavioural model of the two position sensors.
// Assumes: A fire request starts one detection after a delay.
// Notes:   Detections last 12 cycles so the input filter accepts them.
`timescale 1ns/1ps
module sbls_sensor_model (
   input  wire       MCLK,    // Clock
   input  wire       fire1,   // Detect at sensor one
   input  wire       fire2,   // Detect at sensor two
   input  wire [3:0] dly,     // Cycles before detection
   output wire       SENSOR1, // Sensor one
   output wire       SENSOR2  // Sensor two
);
   logic [4:0] c1_reg = '0;
   logic [4:0] c2_reg = '0;
   always @(posedge MCLK) begin
      c1_reg <= fire1 ? 5'd12 + 5'(dly) : c1_reg - 5'(c1_reg != 5'd0);
      c2_reg <= fire2 ? 5'd12 + 5'(dly) : c2_reg - 5'(c2_reg != 5'd0);
   end
   assign SENSOR1 = c1_reg != 5'd0 && c1_reg <= 5'd12;
   assign SENSOR2 = c2_reg != 5'd0 && c2_reg <= 5'd12;
endmodule // sbls_sensor_model

/* File: testbench/sbls_top_checker.sv */
// Purpose: Port-level checks of the stop bar sequencer.
// Assumes: Override is taken from the button level at the clear press.
// Notes:   Lamp checks after a press assume no failure input is present.
`timescale 1ns/1ps
`include "sbls_defs.vh"
module sbls_top_checker #(
   parameter NLAMP = 8,
   parameter NCTL  = 4
) (
   input logic             MCLK,         // Clock
   input logic             RESET_N,      // Reset
   input logic             PSEL,         // APB select
   input logic             PENABLE,      // APB enable
   input logic             PWRITE,       // APB direction
   input logic [11:0]      PADDR,        // APB address
   input logic             PREADY,       // APB ready
   input logic             PSLVERR,      // APB error
   input logic             CLEAR_BTN,    // Clear press
   input logic             OVERRIDE_BTN, // Override
   input logic             SENSOR1,      // Sensor one
   input logic             CTRL_FAIL,    // Control failure
   input logic [NCTL-1:0]  COMM_FAIL,    // Comm failure
   input logic [NCTL-1:0]  COMP_FAIL,    // Component failure
   input logic [NLAMP-1:0] STOP_RED,     // Red lamps
   input logic [NLAMP-1:0] GUARD_YEL,    // Yellow lamps
   input logic             LEAD1_ON,     // Lead one
   input logic             LEAD2_ON,     // Lead two
   input logic             FAIL_IND      // Failed indication
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   logic             clr_reg;
   logic             ovr_reg;
   logic [1:0]       svc_reg;
   logic [NLAMP-1:0] cm;
   wire              nf = !CTRL_FAIL && COMM_FAIL == '0 && COMP_FAIL == '0;
   always_comb begin
      for (int i = 0; i < NLAMP; i++) cm[i] = COMP_FAIL[i % NCTL];
   end
   always_ff @(posedge MCLK) begin
      clr_reg <= CLEAR_BTN;
      if (!RESET_N) begin
         ovr_reg <= 1'b0;
         svc_reg <= 2'b00;
      end else begin
         svc_reg <= {svc_reg[0], PSEL && PENABLE && PREADY && PWRITE &&
                     PADDR == `SBLS_ADDR_SVC};
         if (CLEAR_BTN && !clr_reg) ovr_reg <= OVERRIDE_BTN;
      end
   end
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_press;
      $rose(CLEAR_BTN) && nf;
   endsequence
   sequence s_go;
      STOP_RED == '0 && LEAD1_ON && LEAD2_ON;
   endsequence
   AST_READY_AFTER_SETUP: assert property (s_setup |=> PREADY)
      else $error("no ready in first access cycle");
   AST_READY_ONE_CYCLE: assert property (PREADY |=> !PREADY)
      else $error("ready held longer than one cycle");
   AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
      else $error("error response without ready");
   AST_PRESS_GO: assert property (s_press |-> ##[4:12] s_go)
      else $error("press did not darken bar and light leads");
   AST_NO_YEL_IN_GO: assert property (s_press |-> ##12 (GUARD_YEL == '0) [*8])
      else $error("yellow lit during go configuration");
   AST_SENSOR1_STEP: assert property ($rose(SENSOR1) && LEAD1_ON && LEAD2_ON && !ovr_reg && nf
      |-> ##[4:12] (!LEAD1_ON && LEAD2_ON && STOP_RED != '0))
      else $error("sensor one did not relight bar");
   AST_OVERRIDE_IGNORE: assert property ($rose(SENSOR1) && LEAD1_ON && ovr_reg
      |-> ##4 LEAD1_ON [*8])
      else $error("sensor acted during override cycle");
   AST_RED_YEL_EXCL: assert property ((STOP_RED & GUARD_YEL) == '0)
      else $error("red and yellow lit on one fixture");
   AST_COMP_OFF: assert property ((COMP_FAIL != '0 && $stable(COMP_FAIL)) [*8]
      |-> ((STOP_RED | GUARD_YEL) & cm) == '0)
      else $error("lamp lit on failed controller");
   AST_FAIL_HOLD: assert property ($fell(FAIL_IND) |-> svc_reg != 2'b00)
      else $error("failed indication dropped without service write");
endmodule // sbls_top_checker
bind sbls_top sbls_top_checker #(.NLAMP(NLAMP), .NCTL(NCTL)) i_chk (.MCLK, .RESET_N,
   .PSEL, .PENABLE, .PWRITE, .PADDR, .PREADY, .PSLVERR, .CLEAR_BTN, .OVERRIDE_BTN,
   .SENSOR1, .CTRL_FAIL, .COMM_FAIL, .COMP_FAIL, .STOP_RED, .GUARD_YEL, .LEAD1_ON,
   .LEAD2_ON, .FAIL_IND);

/* File: testbench/stop_bar_lead_on_sequencer_tb.sv */
// Purpose: Self-checking bench for the stop bar sequencer.
// Assumes: Short timer parameters; about six cycles of input latency.
// Notes:   Timer checks sit one tick either side of expiry.
`timescale 1ns/1ps
`include "sbls_defs.vh"
module stop_bar_lead_on_sequencer_tb;
   localparam int   SC = 20;
   localparam [9:0] T1 = 10'd3, T2 = 10'd6, SH = 10'd10;
   logic        MCLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, e;
   logic [11:0] PADDR = '0;
   logic [31:0] PWDATA = '0, PRDATA, r, seed = 32'h9537;
   logic        PREADY, PSLVERR, CLEAR_BTN = 0, OVERRIDE_BTN = 0, CTRL_FAIL = 0;
   logic [3:0]  COMM_FAIL = '0, COMP_FAIL = '0, dly = '0;
   logic [7:0]  LAMP_FAULT = '0, STOP_RED, GUARD_YEL, f;
   logic        LEAD1_ON, LEAD2_ON, FAIL_IND, SENSOR1, SENSOR2, fire1 = 0, fire2 = 0;
   int          fail_count = 0, checks = 0, cyc = 0, n55, naa;
   sbls_top #(.SEC_CYC(SC), .HALF_CYC(7), .T1_SEC(T1), .T2_SEC(T2), .SHUT_SEC(SH)) i_dut (
      .MCLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
      .PSLVERR, .CLEAR_BTN, .OVERRIDE_BTN, .SENSOR1, .SENSOR2, .CTRL_FAIL, .COMM_FAIL,
      .COMP_FAIL, .LAMP_FAULT, .STOP_RED, .GUARD_YEL, .LEAD1_ON, .LEAD2_ON, .FAIL_IND);
   sbls_sensor_model i_sens (.MCLK, .fire1, .fire2, .dly, .SENSOR1, .SENSOR2);
   initial begin
      forever #5 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         stop_test();
      end
   end
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input [31:0] got, input [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_c(input int n);
      repeat (n) @(posedge MCLK);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge MCLK);
      PSEL <= 1;
      PENABLE <= 0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1;
      do begin
         @(posedge MCLK);
         k++;
      end while (PREADY !== 1'b1 && k < 20);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
      chk(k < 20, 1);
   endtask
   // Model of the sequencer: a lit bar drives every lamp, a dead one included.
   task automatic see(input bit bar, input bit l1, input bit l2);
      chk({LEAD2_ON, LEAD1_ON, STOP_RED}, {l2, l1, bar ? 8'hff : 8'h00});
   endtask
   task automatic press(input bit ov);
      @(posedge MCLK);
      OVERRIDE_BTN <= ov;
      CLEAR_BTN <= 1;
      wait_c(12);
      CLEAR_BTN <= 0;
      OVERRIDE_BTN <= 0;
   endtask
   task automatic fire(input int s, input logic [3:0] d);
      @(posedge MCLK);
      dly <= d;
      fire1 <= (s == 1);
      fire2 <= (s == 2);
      @(posedge MCLK);
      fire1 <= 0;
      fire2 <= 0;
      wait_c(23);
   endtask
   initial begin
      wait_c(16);
      RESET_N <= 1;
      wait_c(8);
      apb(0, `SBLS_ADDR_CTRL, 0);
      chk(r, 0);
      apb(0, 12'h010, 0);
      chk(e, 1);
      chk(r, 0);
      see(1, 0, 0);
      press(0);
      see(0, 1, 1);
      apb(0, `SBLS_ADDR_STATUS, 0);
      chk(r[3:1], 3'b110);
      fire(1, 0);
      see(1, 0, 1);
      fire(2, 0);
      see(1, 0, 0);
      press(0);
      wait_c(T1 * SC - SC - 18);
      see(0, 1, 1);
      wait_c(2 * SC + 14);
      see(1, 0, 1);
      wait_c((T2 - T1) * SC - 2 * SC - 14);
      see(1, 0, 1);
      wait_c(2 * SC + 14);
      see(1, 0, 0);
      press(0);
      fire(2, 4);
      see(1, 0, 0);
      wait_c(T2 * SC);
      press(1);
      fire(1, 0);
      fire(2, 0);
      see(0, 1, 1);
      wait_c(T2 * SC + SC + 8 - 62);
      see(1, 0, 0);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         f = seed[7:0];
         LAMP_FAULT <= f;
         wait_c(12);
         see(1, 0, 0);
         apb(0, `SBLS_ADDR_MON, 0);
         chk(r[8:0], {|(f & (f >> 1)), 8'($countones(f))});
      end
      LAMP_FAULT <= 0;
      apb(1, `SBLS_ADDR_CTRL, 32'h1);
      wait_c(12);
      n55 = 0;
      naa = 0;
      repeat (30) begin
         @(posedge MCLK);
         n55 += (GUARD_YEL === 8'h55);
         naa += (GUARD_YEL === 8'haa);
      end
      chk({n55 > 0, naa > 0, 30'(n55 + naa)}, {2'b11, 30'd30});
      chk(STOP_RED, 8'h00);
      press(0);
      chk({GUARD_YEL, LEAD1_ON}, 9'h001);
      wait_c(T2 * SC + SC);
      CTRL_FAIL <= 1;
      wait_c(12);
      chk({STOP_RED, GUARD_YEL, FAIL_IND}, 17'h1);
      apb(1, `SBLS_ADDR_SVC, 1);
      wait_c(2);
      chk(FAIL_IND, 1);
      apb(1, `SBLS_ADDR_CTRL, 0);
      LAMP_FAULT <= 8'h04;
      wait_c(12);
      chk(STOP_RED, 8'hfb);
      CTRL_FAIL <= 0;
      LAMP_FAULT <= 0;
      COMP_FAIL <= 4'h1;
      wait_c(12);
      chk({STOP_RED, GUARD_YEL}, 16'hee00);
      COMP_FAIL <= 0;
      COMM_FAIL <= 4'h2;
      apb(1, `SBLS_ADDR_CTRL, 32'h6);
      wait_c(12);
      n55 = 0;
      repeat (16) begin
         @(posedge MCLK);
         n55 += (GUARD_YEL === 8'h22);
      end
      chk({STOP_RED, 7'h00, n55 > 0 && n55 < 16}, 16'hdd01);
      apb(1, `SBLS_ADDR_CTRL, 32'h0);
      wait_c(SH * SC - SC - 40);
      chk(STOP_RED, 8'hff);
      wait_c(2 * SC + 14);
      chk(STOP_RED & 8'h22, 8'h00);
      COMM_FAIL <= 0;
      wait_c(12);
      apb(1, `SBLS_ADDR_SVC, 1);
      wait_c(2);
      chk(FAIL_IND, 0);
      stop_test();
   end
endmodule // stop_bar_lead_on_sequencer_tb
